// *** design/mcg_clock_gen.sv ***
// Master clock generator: prescaler bypass, ramped loop mode, processor and system clock rates.
//
// Function
// - Processor clock equals master clock or half of it, picked by one bit.
// - System clock for peripherals always runs at the processor clock rate.
// - Bypass mode divides oscillator by (input prescale+1) times (output prescale+1).
// - Bypass with both prescales zero passes the oscillator clock straight through.
// - Input prescale accepts up to 3, output prescale up to 14.
// - Loop mode gives oscillator times (multiply+1) over the two prescale products.
// - Loop mode ramps the multiply factor toward target one unit per interval; a prescale change applies whole at the next ramp boundary.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module mcg_clock_gen
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output mcg_pkg::mcg_ticks_t       ticks
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (mcg_pkg::RAMP_CYCLES < 1)
  begin : g_bad_ramp
    $error("Ramp interval must be at least one cycle.");
  end

  // ==========================================================================
  // Declarations
  // ==========================================================================
  mcg_pkg::mcg_cfg_t             cfg_q;
  logic                          halve_q;
  logic [mcg_pkg::STEP_W-1:0]    step_q;
  logic [mcg_pkg::DIV_W-1:0]     div_q;
  logic [mcg_pkg::ACC_W-1:0]     acc_q;
  logic [mcg_pkg::ACC_W-1:0]     acc_sum;
  logic [mcg_pkg::ACC_W-1:0]     mc_ticks_q;
  logic [mcg_pkg::ACC_W-1:0]     cpu_ticks_q;
  logic                          half_q;
  logic [mcg_pkg::ACC_W:0]       half_sum;
  logic [7:0]                    ramp_cnt_q;
  logic [mcg_pkg::STEP_W-1:0]    target;
  logic [mcg_pkg::DIV_W-1:0]     div_d;
  logic                          loop_mode;
  logic                          locked;
  logic                          wr_en;
  logic                          rd_setup;
  logic                          addr_ok;
  logic [31:0]                   prdata_q;

  assign loop_mode = (cfg_q.mode == mcg_pkg::MODE_LOOP);
  assign target    = loop_mode ? mcg_pkg::STEP_W'(cfg_q.mul) + 6'h01 : 6'h01;
  // The prescale product reaches sixty, so both factors are widened before multiplying.
  assign div_d     = (mcg_pkg::DIV_W'(cfg_q.idiv) + 6'h01)
                     * (mcg_pkg::DIV_W'(cfg_q.odiv) + 6'h01);
  assign locked    = (step_q == target) && (div_q == div_d);

  // ==========================================================================
  // APB slave
  // ==========================================================================
  assign addr_ok  = (paddr == mcg_pkg::SYS_CTRL_OFFSET) || (paddr == mcg_pkg::CLK_CFG_OFFSET)
                    || (paddr == mcg_pkg::STATUS_OFFSET);
  assign wr_en    = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_ok;
  assign prdata   = prdata_q;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      case (paddr)
        mcg_pkg::SYS_CTRL_OFFSET: prdata_q <= {31'h0000_0000, halve_q};
        mcg_pkg::CLK_CFG_OFFSET:  prdata_q <= {19'h0_0000, cfg_q.mul, cfg_q.odiv,
                                               cfg_q.idiv, cfg_q.mode};
        mcg_pkg::STATUS_OFFSET:   prdata_q <= {22'h00_0000, half_q, locked, 2'h0, step_q};
        default:                  prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      halve_q <= mcg_pkg::HALVE_RST;
    end
    else if (wr_en && paddr == mcg_pkg::SYS_CTRL_OFFSET)
    begin
      halve_q <= pwdata[mcg_pkg::HALVE_BIT];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cfg_q.mode <= mcg_pkg::MODE_RST;
      cfg_q.idiv <= mcg_pkg::IDIV_RST;
      cfg_q.odiv <= mcg_pkg::ODIV_RST;
      cfg_q.mul  <= mcg_pkg::MUL_RST;
    end
    else if (wr_en && paddr == mcg_pkg::CLK_CFG_OFFSET)
    begin
      if (pwdata[mcg_pkg::MODE_LSB +: 2] != mcg_pkg::MODE_RESERVED)
      begin
        cfg_q.mode <= pwdata[mcg_pkg::MODE_LSB +: 2];
      end
      cfg_q.idiv <= pwdata[mcg_pkg::IDIV_LSB +: mcg_pkg::IDIV_W];
      if (pwdata[mcg_pkg::ODIV_LSB +: mcg_pkg::ODIV_W] <= mcg_pkg::ODIV_MAX)
      begin
        cfg_q.odiv <= pwdata[mcg_pkg::ODIV_LSB +: mcg_pkg::ODIV_W];
      end
      cfg_q.mul <= pwdata[mcg_pkg::MUL_LSB +: mcg_pkg::MUL_W];
    end
  end

  // ==========================================================================
  // Rate control: bypass jumps at once, loop ramps one unit per interval
  // ==========================================================================
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ramp_cnt_q <= 8'h00;
    end
    else if (ramp_cnt_q == 8'(mcg_pkg::RAMP_CYCLES - 1))
    begin
      ramp_cnt_q <= 8'h00;
    end
    else
    begin
      ramp_cnt_q <= ramp_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      step_q <= 6'h01;
    end
    else if (!loop_mode)
    begin
      step_q <= 6'h01;
    end
    else if (ramp_cnt_q == 8'h00 && step_q < target)
    begin
      step_q <= step_q + 6'h01;
    end
    else if (ramp_cnt_q == 8'h00 && step_q > target)
    begin
      step_q <= step_q - 6'h01;
    end
  end

  // Loop mode takes the divisor over only on a ramp boundary; bypass takes it over every cycle.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      div_q <= 6'h01;
    end
    else if (!loop_mode || ramp_cnt_q == 8'h00)
    begin
      div_q <= div_d;
    end
  end

  // ==========================================================================
  // Master clock: fractional accumulator, ticks per oscillator cycle
  // ==========================================================================
  // Bypass adds one at once, so a loop step left over from a mode change never leaks through.
  assign acc_sum = acc_q + (loop_mode ? mcg_pkg::ACC_W'(step_q) : 7'h01);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      acc_q      <= 7'h00;
      mc_ticks_q <= 7'h00;
    end
    else if (acc_q >= mcg_pkg::ACC_W'(div_q))
    begin
      acc_q      <= 7'h00;
      mc_ticks_q <= 7'h00;
    end
    else
    begin
      acc_q      <= acc_sum % mcg_pkg::ACC_W'(div_q);
      mc_ticks_q <= acc_sum / mcg_pkg::ACC_W'(div_q);
    end
  end

  // ==========================================================================
  // Processor and system clock
  // ==========================================================================
  assign half_sum = {1'b0, mc_ticks_q} + {7'h00, half_q};

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      half_q      <= 1'b0;
      cpu_ticks_q <= 7'h00;
    end
    else if (halve_q)
    begin
      half_q      <= half_sum[0];
      cpu_ticks_q <= half_sum[mcg_pkg::ACC_W:1];
    end
    else
    begin
      half_q      <= 1'b0;
      cpu_ticks_q <= mc_ticks_q;
    end
  end

  logic [mcg_pkg::ACC_W-1:0] mc_ticks_d1;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      mc_ticks_d1 <= 7'h00;
    end
    else
    begin
      mc_ticks_d1 <= mc_ticks_q;
    end
  end

  assign ticks.mc_ticks  = mc_ticks_d1;
  assign ticks.cpu_ticks = cpu_ticks_q;
  assign ticks.sys_ticks = cpu_ticks_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_sys_cpu_equal: assert property (ticks.sys_ticks == ticks.cpu_ticks)
    else $error("System clock rate differs from processor clock rate.");

  a_cpu_full_rate: assert property (
    !halve_q && !$past(halve_q) |-> ticks.cpu_ticks == ticks.mc_ticks)
    else $error("Processor clock not equal to master clock.");

  a_cpu_half_rate: assert property (
    halve_q && $past(halve_q) && $past(halve_q, 2)
    && $past(ticks.mc_ticks) == 7'h01 && ticks.mc_ticks == 7'h01
    |-> ticks.cpu_ticks != $past(ticks.cpu_ticks))
    else $error("Processor clock not at half the master clock.");

  a_bypass_step: assert property (!loop_mode |=> step_q == 6'h01)
    else $error("Bypass mode step is not one.");

  a_bypass_pass: assert property (
    !loop_mode && cfg_q.idiv == 2'h0 && cfg_q.odiv == 4'h0
    && div_q == 6'h01 && acc_q == 7'h00 |=> mc_ticks_q == 7'h01)
    else $error("Bypass with unit prescale does not pass the oscillator through.");

  a_odiv_limit: assert property (cfg_q.odiv <= mcg_pkg::ODIV_MAX)
    else $error("Output prescale above fourteen.");

  a_ramp_smooth: assert property (
    loop_mode && $past(loop_mode)
    |-> (step_q - $past(step_q) <= 6'h01) || ($past(step_q) - step_q <= 6'h01))
    else $error("Loop step changed by more than one.");

  a_ramp_up: assert property (
    loop_mode && ramp_cnt_q == 8'h00 && step_q < target
    && $stable(cfg_q) |=> step_q == $past(step_q) + 6'h01)
    else $error("Loop rate does not advance toward target.");

  a_reserved_keep: assert property (
    wr_en && paddr == mcg_pkg::CLK_CFG_OFFSET && pwdata[1:0] == mcg_pkg::MODE_RESERVED
    |=> cfg_q.mode == $past(cfg_q.mode))
    else $error("Reserved mode encoding changed the clock selection.");

  c_bypass_pass: cover property (!loop_mode && div_q == 6'h01 ##1 mc_ticks_q == 7'h01);
  c_loop_locked: cover property (loop_mode && cfg_q.mul != 5'h00 && locked);
  c_halved:      cover property (halve_q && ticks.cpu_ticks != 7'h00);

endmodule

// *** pkg/mcg_pkg.sv ***
// Package holding register map, field layout, reset values and timing for the clock generator.
package mcg_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] SYS_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CLK_CFG_OFFSET  = 8'h04;
  localparam logic [7:0] STATUS_OFFSET   = 8'h08;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int HALVE_BIT    = 0;
  localparam int MODE_LSB     = 0;
  localparam int IDIV_LSB     = 2;
  localparam int ODIV_LSB     = 4;
  localparam int MUL_LSB      = 8;
  localparam int ST_STEP_LSB  = 0;
  localparam int ST_LOCK_BIT  = 8;
  localparam int ST_HALF_BIT  = 9;

  // ==========================================================================
  // Field widths and limits
  // ==========================================================================
  localparam int IDIV_W = 2;
  localparam int ODIV_W = 4;
  localparam int MUL_W  = 5;
  localparam int STEP_W = 6;
  localparam int DIV_W  = 6;
  localparam int ACC_W  = 7;
  localparam logic [3:0] ODIV_MAX = 4'hE;

  // ==========================================================================
  // Clock source modes and reset values
  // ==========================================================================
  localparam logic [1:0] MODE_LOOP     = 2'h3;
  localparam logic [1:0] MODE_RESERVED = 2'h2;
  localparam logic [1:0] MODE_RST      = 2'h0;
  localparam logic [1:0] IDIV_RST      = 2'h0;
  localparam logic [3:0] ODIV_RST      = 4'h0;
  localparam logic [4:0] MUL_RST       = 5'h0;
  localparam logic       HALVE_RST     = 1'b0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CORE_CLK_HZ  = 10_000_000;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_CYCLES  = (RAMP_STEP_NS * (CORE_CLK_HZ / 1_000_000)) / 1000;

  typedef struct packed {
    logic [1:0]        mode;
    logic [IDIV_W-1:0] idiv;
    logic [ODIV_W-1:0] odiv;
    logic [MUL_W-1:0]  mul;
  } mcg_cfg_t;

  typedef struct packed {
    logic [ACC_W-1:0] mc_ticks;
    logic [ACC_W-1:0] cpu_ticks;
    logic [ACC_W-1:0] sys_ticks;
  } mcg_ticks_t;

endpackage

// *** tb/mcg_apb_host.sv ***
// APB host model that issues register transfers to the clock generator.
`timescale 1ns/1ps
module mcg_apb_host
(
  input  wire logic        core_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdata;
  logic        rerr;

  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // ==========================================================================
  // Transfer
  // ==========================================================================
  // The request is held until pready is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// *** tb/master_clock_generation_tb_top.sv ***
// Self-checking testbench for the master clock generator.
`timescale 1ns/1ps
module master_clock_generation_tb_top;
  logic                core_clk = 1'b0;
  logic                reset    = 1'b1;
  logic                psel, penable, pwrite, pready, pslverr;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata;
  mcg_pkg::mcg_ticks_t ticks;
  int                  bad_count = 0;
  int                  tests_run = 0;
  int                  cyc = 0;
  int                  i, o, m, e;

  always #50 core_clk = ~core_clk;

  mcg_clock_gen i_mcg_clock_gen (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ticks(ticks));

  mcg_apb_host i_mcg_apb_host (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ==========================================================================
  // Reporting
  // ==========================================================================
  task automatic wrap_up;
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Rates are counted over a window whose start phase is free, so one tick of slack.
  task automatic chk_near(string name, int exp, int got);
    tests_run++;
    if (got > exp + 1 || got < exp - 1)
    begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Bus and measurement helpers
  // ==========================================================================
  task automatic rd(logic [7:0] a, logic [31:0] exp, logic err);
    i_mcg_apb_host.xfer(1'b0, a, 32'h0);
    chk("prdata", exp, i_mcg_apb_host.rdata);
    chk("pslverr", {31'h0, err}, {31'h0, i_mcg_apb_host.rerr});
  endtask

  task automatic cfg(int md, int ip, int op, int mu);
    i_mcg_apb_host.xfer(1'b1, mcg_pkg::CLK_CFG_OFFSET, 32'((mu << 8) | (op << 4) | (ip << 2) | md));
  endtask

  // Sums tick counts over n cycles; exp below zero skips the rate check.
  task automatic meas(int n, int exp, bit halve, bit grad);
    int mc, cp;
    logic [6:0] last;
    mc = 0;
    cp = 0;
    last = ticks.mc_ticks;
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      mc += ticks.mc_ticks;
      cp += ticks.cpu_ticks;
      chk("sys_ticks", {25'h0, ticks.cpu_ticks}, {25'h0, ticks.sys_ticks});
      chk("ticks_known", 32'h0, 32'($isunknown(ticks)));
      if (grad)
        chk("ramp_step", 32'h1, 32'(ticks.mc_ticks + 1 >= last && last + 1 >= ticks.mc_ticks));
      last = ticks.mc_ticks;
    end
    if (exp >= 0)
    begin
      chk_near("mc_rate", exp, mc);
      chk_near("cpu_rate", halve ? exp / 2 : exp, cp);
    end
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    void'($urandom(32'h8c06));
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rd(mcg_pkg::SYS_CTRL_OFFSET, 32'h0, 1'b0);
    rd(mcg_pkg::CLK_CFG_OFFSET, 32'h0, 1'b0);
    rd(8'h0C, 32'h0, 1'b0 ^ 1'b1);
    i_mcg_apb_host.xfer(1'b1, mcg_pkg::STATUS_OFFSET, 32'hFFFF);
    chk("status_wr_err", 32'h0, {31'h0, i_mcg_apb_host.rerr});
    repeat (8)
    begin
      @(posedge core_clk);
      #1;
      chk("pass_through", 32'h1, {25'h0, ticks.mc_ticks});
    end
    meas(240, 240, 1'b0, 1'b0);
    cfg(0, 3, 14, 0);
    rd(mcg_pkg::CLK_CFG_OFFSET, 32'hEC, 1'b0);
    repeat (80) @(posedge core_clk);
    meas(240, 4, 1'b0, 1'b0);
    repeat (4)
    begin
      i = $urandom_range(3);
      o = $urandom_range(14);
      cfg($urandom_range(1), i, o, 0);
      repeat (80) @(posedge core_clk);
      meas(240, 240 / ((i + 1) * (o + 1)), 1'b0, 1'b0);
    end
    cfg(0, 0, 0, 0);
    cfg(0, 1, 15, 0);
    rd(mcg_pkg::CLK_CFG_OFFSET, 32'h04, 1'b0);
    cfg(0, 0, 0, 0);
    repeat (20) @(posedge core_clk);
    cfg(3, 0, 0, 7);
    meas(100, -1, 1'b0, 1'b1);
    meas(240, 1920, 1'b0, 1'b0);
    rd(mcg_pkg::STATUS_OFFSET, 32'((1 << mcg_pkg::ST_LOCK_BIT) | 8), 1'b0);
    repeat (3)
    begin
      m = $urandom_range(7);
      i = $urandom_range(1);
      o = $urandom_range(2);
      cfg(3, i, o, m);
      repeat (120) @(posedge core_clk);
      e = 240 * (m + 1) / ((i + 1) * (o + 1));
      meas(240, e, 1'b0, 1'b0);
    end
    i_mcg_apb_host.xfer(1'b1, mcg_pkg::SYS_CTRL_OFFSET, 32'h1);
    rd(mcg_pkg::SYS_CTRL_OFFSET, 32'h1, 1'b0);
    meas(240, e, 1'b1, 1'b0);
    cfg(2, i, o, m);
    rd(mcg_pkg::CLK_CFG_OFFSET, 32'((m << 8) | (o << 4) | (i << 2) | 3), 1'b0);
    meas(240, e, 1'b1, 1'b0);
    wrap_up();
  end
endmodule
